/* rtl/ppmc_hs_chan.sv */
// One handshake channel: double buffer, primary and auxiliary handshake pins
`timescale 1ns/1ns
module ppmc_hs_chan #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic resetn,
	input wire ppmc_pkg::ppmc_chan_ctl_s ctl,
	input wire logic primAsr,
	input wire logic auxAsr,
	input wire logic [W-1:0] pins,
	input wire logic wrStb,
	input wire logic [W-1:0] wrData,
	input wire logic rdStb,
	output logic [W-1:0] inData,
	output logic [W-1:0] outData,
	output logic inFull,
	output logic outAvail,
	output logic auxOut,
	output logic auxOe,
	output logic primEdge,
	output logic auxEdge
);
	import ppmc_pkg::*;

	localparam int PW = $clog2(HS_PULSE_CYC + 1);

	logic primPrev_q;
	logic auxPrev_q;
	logic [W-1:0] store_q [2];
	logic [W-1:0] single_q;
	logic [1:0] cnt_q;
	logic [PW-1:0] pulse_q;

	wire hsOn = ctl.enable & (ctl.latchMode | ctl.ackMode);
	wire primFall = ~primAsr & primPrev_q;
	wire notFull = cnt_q != 2'd2;
	wire notEmpty = cnt_q != 2'd0;
	// Latch on asserted edge while room is left
	wire take = hsOn & ctl.latchMode & primEdge & notFull;
	wire load = ctl.ackMode & wrStb & notFull;
	// Output word is taken when the peripheral releases its acknowledge
	wire pop = (ctl.latchMode & rdStb & notEmpty) | (hsOn & ctl.ackMode & primFall & notEmpty);
	wire push = take | load;
	wire wrIdx = pop ? (cnt_q == 2'd2) : cnt_q[0];
	wire [W-1:0] newWord = take ? pins : wrData;
	wire pulseStart = ctl.latchMode ? take : ((load & ~notEmpty) | (pop & ~notFull));

	assign primEdge = primAsr & ~primPrev_q;
	assign auxEdge = auxAsr & ~auxPrev_q;
	assign inData = ctl.latchMode ? store_q[0] : pins;
	assign outData = ctl.ackMode ? store_q[0] : single_q;
	assign inFull = ctl.latchMode & notEmpty;
	assign outAvail = ctl.ackMode & notEmpty;
	assign auxOe = ctl.auxCtl[AUX_DIR_BIT];

	always_comb begin
		unique case (ctl.auxCtl)
			AUX_OUT_ASR: auxOut = 1'b1;
			AUX_ILOCK: auxOut = hsOn & (ctl.latchMode ? notFull : notEmpty);
			AUX_PULSE: auxOut = hsOn & (pulse_q != '0);
			default: auxOut = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			primPrev_q <= 1'b0;
			auxPrev_q <= 1'b0;
		end else begin
			primPrev_q <= primAsr;
			auxPrev_q <= auxAsr;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= 2'd0;
			store_q[0] <= '0;
			store_q[1] <= '0;
		end else begin
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
			if (pop) begin
				store_q[0] <= store_q[1];
			end
			if (push) begin
				store_q[wrIdx] <= newWord;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			single_q <= '0;
			pulse_q <= '0;
		end else begin
			if (wrStb & ~ctl.ackMode) begin
				single_q <= wrData;
			end
			if (pulseStart) begin
				pulse_q <= PW'(HS_PULSE_CYC);
			end else if (pulse_q != '0) begin
				pulse_q <= pulse_q - 1'b1;
			end
		end
	end
endmodule

/* rtl/ppmc_port_mode_ctrl.sv */
// Port pair mode control with register slave, pin muxing and direction
`timescale 1ns/1ns
// Behaviour
// - Two-bit global field selects four port modes
// - Each port control holds a two-bit submode
// - Mode and submode fix port and pins
// - Mode 0 sub 00: latched input, first pin latches
// - Mode 0 sub 01: buffered output, live input
// - Second pin: status, output or handshake partner
// - Sub 1X: single output, live input, status pins
// - Port B pair mirrors port A pair
// - 16-bit mode: B low byte, A pins status
// - 16-bit sub X0: latched word by third pin
// - 16-bit output: third pin acknowledges, fourth handshakes
// - Bidirectional 8-bit: port B double buffered, submodes ignored
// - First pin acknowledges output and enables drivers
// - Third pin latches input, fourth completes handshake
// - Bidirectional 16-bit: A high, B low byte
// - Host data path eight bits wide
// - Five select bits address the registers
// - Handshake pin sense programmable in low bits
// - Status register shows live handshake pin levels
// - Reset clears control and direction registers
module ppmc_port_mode_ctrl (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [ppmc_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [ppmc_pkg::DATA_W-1:0] avs_writedata,
	output logic [ppmc_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [7:0] portAIn,
	output logic [7:0] portAOut,
	output logic [7:0] portAOe,
	input wire logic [7:0] portBIn,
	output logic [7:0] portBOut,
	output logic [7:0] portBOe,
	input wire logic handshakeAIn,
	input wire logic handshakeAAuxIn,
	output logic handshakeAAuxOut,
	output logic handshakeAAuxOe,
	input wire logic handshakeBIn,
	input wire logic handshakeBAuxIn,
	output logic handshakeBAuxOut,
	output logic handshakeBAuxOe
);
	import ppmc_pkg::*;

	localparam int SYNC_W = 20;

	logic [SYNC_W-1:0] sync1_q;
	logic [SYNC_W-1:0] sync2_q;
	logic [7:0] gcr_q;
	logic [7:0] ddrA_q;
	logic [7:0] ddrB_q;
	logic [7:0] ctlA_q;
	logic [7:0] ctlB_q;
	logic [7:0] hiHold_q;
	logic [3:0] flag_q;
	logic ack_q;
	ppmc_chan_ctl_s aCtl;
	ppmc_chan_ctl_s bCtl;
	logic [WORD_W-1:0] aIn;
	logic [WORD_W-1:0] aOut;
	logic [WORD_W-1:0] bIn;
	logic [WORD_W-1:0] bOut;
	logic aFull;
	logic aAvail;
	logic bFull;
	logic bAvail;
	logic aAuxAsr;
	logic bAuxAsr;
	logic aAuxOe;
	logic bAuxOe;
	logic aPrimEdge;
	logic aAuxEdge;
	logic bPrimEdge;
	logic bAuxEdge;

	// Pins pass two flops; reset at pull-up idle so no false edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sync1_q <= '1;
			sync2_q <= '1;
		end else begin
			sync1_q <= {handshakeBAuxIn, handshakeBIn, handshakeAAuxIn, handshakeAIn, portBIn, portAIn};
			sync2_q <= sync1_q;
		end
	end

	wire [7:0] pa = sync2_q[7:0];
	wire [7:0] pb = sync2_q[15:8];
	wire [3:0] hLvl = sync2_q[19:16];
	wire [3:0] sense = gcr_q[GCR_SENSE_HI:0];
	// Asserted level of each handshake pin after sense
	wire [3:0] hAsr = ~(hLvl ^ sense);

	// Mode decode
	wire ppmc_mode_e mode = ppmc_mode_e'(gcr_q[GCR_MODE_HI:GCR_MODE_LO]);
	wire bidir = mode == MODE_BI8 || mode == MODE_BI16;
	wire wide = mode == MODE_UNI16 || mode == MODE_BI16;
	wire [1:0] subA = ctlA_q[CTL_SUB_HI:CTL_SUB_LO];
	wire [1:0] subB = ctlB_q[CTL_SUB_HI:CTL_SUB_LO];

	// Channel roles for each mode and submode
	always_comb begin
		aCtl = '0;
		bCtl = '0;
		aCtl.enable = gcr_q[GCR_EN12];
		bCtl.enable = gcr_q[GCR_EN34];
		// Bidirectional modes force a handshake code on the second and fourth pins
		aCtl.auxCtl = bidir ? {2'b11, ctlA_q[CTL_AUX_LO]} : ctlA_q[CTL_AUX_HI:CTL_AUX_LO];
		bCtl.auxCtl = bidir ? {2'b11, ctlB_q[CTL_AUX_LO]} : ctlB_q[CTL_AUX_HI:CTL_AUX_LO];
		unique case (mode)
			MODE_UNI8: begin
				aCtl.latchMode = subA == SUB_LATCH;
				aCtl.ackMode = subA == SUB_ACK;
				bCtl.latchMode = subB == SUB_LATCH;
				bCtl.ackMode = subB == SUB_ACK;
			end
			MODE_UNI16: begin
				bCtl.latchMode = ~subB[0];
				bCtl.ackMode = subB[0];
			end
			MODE_BI8, MODE_BI16: begin
				aCtl.ackMode = 1'b1;
				bCtl.latchMode = 1'b1;
			end
		endcase
	end

	// Bus slave: one wait cycle, then the answer
	wire req = avs_read | avs_write;
	wire first = req & ~ack_q;
	wire wrEn = avs_write & ack_q;
	wire rdEn = avs_read & ack_q;
	assign avs_waitrequest = first;

	// Register select decode
	wire selGcr = avs_address == OFF_GCR;
	wire selDdrA = avs_address == OFF_DDRA;
	wire selDdrB = avs_address == OFF_DDRB;
	wire selCtlA = avs_address == OFF_CTLA;
	wire selCtlB = avs_address == OFF_CTLB;
	wire selDataA = avs_address == OFF_DATA_A;
	wire selDataB = avs_address == OFF_DATA_B;
	wire selStat = avs_address == OFF_STAT;

	wire wrDataA = wrEn & selDataA;
	wire wrDataB = wrEn & selDataB;
	wire rdDataA = rdEn & selDataA;
	wire rdDataB = rdEn & selDataB;

	// Data routing into the channels
	wire [WORD_W-1:0] bWrData = {wide ? hiHold_q : 8'h00, avs_writedata};
	wire [WORD_W-1:0] aWrData = bidir ? bWrData : {8'h00, avs_writedata};
	wire aWr = bidir ? wrDataB : (wrDataA & mode == MODE_UNI8);
	wire bWr = wrDataB & ~bidir;
	wire aRd = rdDataA & mode == MODE_UNI8;
	wire [WORD_W-1:0] aPins = {8'h00, pa};
	wire [WORD_W-1:0] bPins = wide ? {pa, pb} : {8'h00, pb};

	// Readback per bit in unidirectional modes and for bit port A in 8-bit bidirectional mode: outputs show the latch, inputs the buffer or pin
	wire [7:0] rdA8 = (ddrA_q & aOut[7:0]) | (~ddrA_q & aIn[7:0]);
	wire [7:0] rdA16 = (ddrA_q & bOut[15:8]) | (~ddrA_q & bIn[15:8]);
	wire [7:0] rdABit = (ddrA_q & hiHold_q) | (~ddrA_q & pa);
	wire [7:0] rdBUni = (ddrB_q & bOut[7:0]) | (~ddrB_q & bIn[7:0]);
	wire [7:0] rdA = mode == MODE_UNI8 ? rdA8 : mode == MODE_UNI16 ? rdA16 : mode == MODE_BI8 ? rdABit : bIn[15:8];
	wire [7:0] rdB = bidir ? bIn[7:0] : rdBUni;

	wire [7:0] rdMux =
		selGcr ? gcr_q :
		selDdrA ? ddrA_q :
		selDdrB ? ddrB_q :
		selCtlA ? ctlA_q :
		selCtlB ? ctlB_q :
		selDataA ? rdA :
		selDataB ? rdB :
		selStat ? {hLvl, flag_q} :
		8'h00;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ack_q <= 1'b0;
			avs_readdata <= 8'h00;
		end else begin
			ack_q <= first;
			if (avs_read & first) begin
				avs_readdata <= rdMux;
			end
		end
	end

	// Control registers cleared by reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			gcr_q <= RST_GCR;
			ctlA_q <= RST_CTL;
			ctlB_q <= RST_CTL;
		end else begin
			if (wrEn & selGcr) gcr_q <= avs_writedata;
			if (wrEn & selCtlA) ctlA_q <= avs_writedata;
			if (wrEn & selCtlB) ctlB_q <= avs_writedata;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ddrA_q <= RST_DDR;
			ddrB_q <= RST_DDR;
			hiHold_q <= RST_DATA;
		end else begin
			if (wrEn & selDdrA) ddrA_q <= avs_writedata;
			if (wrEn & selDdrB) ddrB_q <= avs_writedata;
			if (wrDataA) hiHold_q <= avs_writedata;
		end
	end

	// Edge flags: a set in the clearing cycle wins
	wire [3:0] flagSet = {bAuxEdge & ~bAuxOe, bPrimEdge, aAuxEdge & ~aAuxOe, aPrimEdge};
	wire [3:0] flagClr = (wrEn & selStat) ? avs_writedata[3:0] : 4'h0;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flag_q <= 4'h0;
		end else begin
			flag_q <= (flag_q & ~flagClr) | flagSet;
		end
	end

	ppmc_hs_chan #(.W(WORD_W)) chanA (
		.clk(clk),
		.resetn(resetn),
		.ctl(aCtl),
		.primAsr(hAsr[0]),
		.auxAsr(hAsr[1]),
		.pins(aPins),
		.wrStb(aWr),
		.wrData(aWrData),
		.rdStb(aRd),
		.inData(aIn),
		.outData(aOut),
		.inFull(aFull),
		.outAvail(aAvail),
		.auxOut(aAuxAsr),
		.auxOe(aAuxOe),
		.primEdge(aPrimEdge),
		.auxEdge(aAuxEdge)
	);

	ppmc_hs_chan #(.W(WORD_W)) chanB (
		.clk(clk),
		.resetn(resetn),
		.ctl(bCtl),
		.primAsr(hAsr[2]),
		.auxAsr(hAsr[3]),
		.pins(bPins),
		.wrStb(bWr),
		.wrData(bWrData),
		.rdStb(rdDataB),
		.inData(bIn),
		.outData(bOut),
		.inFull(bFull),
		.outAvail(bAvail),
		.auxOut(bAuxAsr),
		.auxOe(bAuxOe),
		.primEdge(bPrimEdge),
		.auxEdge(bAuxEdge)
	);

	// Auxiliary pins driven at the programmed sense
	assign handshakeAAuxOut = ~(aAuxAsr ^ sense[1]);
	assign handshakeBAuxOut = ~(bAuxAsr ^ sense[3]);
	assign handshakeAAuxOe = aAuxOe;
	assign handshakeBAuxOe = bAuxOe;

	// Port drivers per mode
	wire [7:0] drvOn = {8{hAsr[0]}};
	assign portAOut = mode == MODE_UNI8 ? aOut[7:0] : mode == MODE_BI8 ? hiHold_q : mode == MODE_UNI16 ? bOut[15:8] : aOut[15:8];
	assign portBOut = bidir ? aOut[7:0] : bOut[7:0];
	assign portAOe = mode == MODE_BI16 ? drvOn : ddrA_q;
	assign portBOe = bidir ? drvOn : ddrB_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	property p_mode_write;
		avs_write && !avs_waitrequest && selGcr
		|=> gcr_q[GCR_MODE_HI:GCR_MODE_LO] == $past(avs_writedata[GCR_MODE_HI:GCR_MODE_LO]);
	endproperty
	a_mode_write: assert property (p_mode_write)
		else $error("Mode field not taken from bus write");

	property p_bus_answer;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_bus_answer: assert property (p_bus_answer)
		else $error("Bus request not answered in the next cycle");

	property p_uni_dir;
		mode == MODE_UNI8 |-> portAOe == ddrA_q && portBOe == ddrB_q;
	endproperty
	a_uni_dir: assert property (p_uni_dir)
		else $error("Unidirectional pin direction differs from direction registers");

	property p_bidir_dir;
		bidir |-> portBOe == {8{hAsr[0]}};
	endproperty
	a_bidir_dir: assert property (p_bidir_dir)
		else $error("Bidirectional drivers not following first handshake pin");

	property p_wide_dir;
		mode == MODE_BI16 |-> portAOe == portBOe && portAOut == aOut[15:8];
	endproperty
	a_wide_dir: assert property (p_wide_dir)
		else $error("High byte not driven with low byte in wide bidirectional mode");

	property p_latch_a;
		mode == MODE_UNI8 && subA == SUB_LATCH && gcr_q[GCR_EN12] && $rose(hAsr[0]) |=> aFull;
	endproperty
	a_latch_a: assert property (p_latch_a)
		else $error("Input not latched on first handshake edge");

	property p_latch_b;
		bidir && gcr_q[GCR_EN34] && $rose(hAsr[2]) |=> bFull;
	endproperty
	a_latch_b: assert property (p_latch_b)
		else $error("Bidirectional input not latched on third handshake edge");

	property p_status_live;
		avs_read && !avs_waitrequest && selStat |-> avs_readdata[7:4] == $past(hLvl);
	endproperty
	a_status_live: assert property (p_status_live)
		else $error("Status read does not show handshake levels");

	property p_aux_sense;
		!bidir && ctlA_q[CTL_AUX_HI:CTL_AUX_LO] == AUX_OUT_ASR |-> handshakeAAuxOe && handshakeAAuxOut == gcr_q[1];
	endproperty
	a_aux_sense: assert property (p_aux_sense)
		else $error("Asserted second pin not at programmed sense");

	property p_no_hs_a;
		mode == MODE_UNI16 && ctlA_q[CTL_AUX_HI:CTL_AUX_LO] == AUX_ILOCK |-> handshakeAAuxOut == !gcr_q[1];
	endproperty
	a_no_hs_a: assert property (p_no_hs_a)
		else $error("Port A handshake active in wide unidirectional mode");

	property p_flag_set;
		$rose(hAsr[2]) |=> flag_q[2];
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("Third pin edge flag lost");

	c_bidir_out: cover property (bidir && aAvail ##1 $rose(hAsr[0]));
	c_wide_latch: cover property (mode == MODE_UNI16 && $rose(hAsr[2]) ##1 bFull);
	c_aux_pulse: cover property (aCtl.auxCtl == AUX_PULSE && aAvail && handshakeAAuxOe);
	c_flag_clear: cover property (avs_write && !avs_waitrequest && selStat && flag_q != 4'h0);
	c_word_out: cover property (mode == MODE_UNI16 && bAvail);
endmodule

/* shared/ppmc_pkg.sv */
// Shared constants and types of the parallel port mode control block
package ppmc_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int WORD_W = 16;

	localparam logic [ADDR_W-1:0] OFF_GCR = 5'h00;
	localparam logic [ADDR_W-1:0] OFF_DDRA = 5'h02;
	localparam logic [ADDR_W-1:0] OFF_DDRB = 5'h03;
	localparam logic [ADDR_W-1:0] OFF_CTLA = 5'h06;
	localparam logic [ADDR_W-1:0] OFF_CTLB = 5'h07;
	localparam logic [ADDR_W-1:0] OFF_DATA_A = 5'h08;
	localparam logic [ADDR_W-1:0] OFF_DATA_B = 5'h09;
	localparam logic [ADDR_W-1:0] OFF_STAT = 5'h0d;

	localparam int GCR_MODE_HI = 7;
	localparam int GCR_MODE_LO = 6;
	localparam int GCR_EN34 = 5;
	localparam int GCR_EN12 = 4;
	localparam int GCR_SENSE_HI = 3;
	localparam int CTL_SUB_HI = 7;
	localparam int CTL_SUB_LO = 6;
	localparam int CTL_AUX_HI = 5;
	localparam int CTL_AUX_LO = 3;
	localparam int AUX_DIR_BIT = 2;

	localparam logic [DATA_W-1:0] RST_GCR = 8'h00;
	localparam logic [DATA_W-1:0] RST_DDR = 8'h00;
	localparam logic [DATA_W-1:0] RST_CTL = 8'h00;
	localparam logic [DATA_W-1:0] RST_DATA = 8'h00;

	localparam logic [1:0] SUB_LATCH = 2'h0;
	localparam logic [1:0] SUB_ACK = 2'h1;
	localparam logic [2:0] AUX_OUT_NEG = 3'h4;
	localparam logic [2:0] AUX_OUT_ASR = 3'h5;
	localparam logic [2:0] AUX_ILOCK = 3'h6;
	localparam logic [2:0] AUX_PULSE = 3'h7;

	localparam int CLK_PERIOD_NS = 100;
	localparam int HS_PULSE_NS = 400;
	localparam int HS_PULSE_CYC = (HS_PULSE_NS / CLK_PERIOD_NS) < 1 ? 1 : (HS_PULSE_NS / CLK_PERIOD_NS);

	typedef enum logic [1:0] {MODE_UNI8, MODE_UNI16, MODE_BI8, MODE_BI16} ppmc_mode_e;

	typedef struct packed {
		logic enable;
		logic latchMode;
		logic ackMode;
		logic [2:0] auxCtl;
	} ppmc_chan_ctl_s;
endpackage

/* verification/parallel_port_mode_control_tb.sv */
// Self-checking bench of the port pair mode control block
`timescale 1ns/1ns
module parallel_port_mode_control_tb;
	import ppmc_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [ADDR_W-1:0] address = '0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [DATA_W-1:0] writeData = '0;
	logic [DATA_W-1:0] readData;
	logic waitReq;
	logic [7:0] aIn, aOut, aOe, bIn, bOut, bOe;
	logic h1, h2In, h2Out, h2Oe, h3, h4In, h4Out, h4Oe;
	logic [7:0] rv;
	logic [ADDR_W-1:0] regList [5] = '{OFF_GCR, OFF_DDRA, OFF_DDRB, OFF_CTLA, OFF_CTLB};
	int failures = 0;
	int check_count = 0;

	always #50 clk = ~clk;

	ppmc_port_mode_ctrl dut (.clk(clk), .resetn(resetn), .avs_address(address), .avs_read(read), .avs_write(write),
		.avs_writedata(writeData), .avs_readdata(readData), .avs_waitrequest(waitReq), .portAIn(aIn),
		.portAOut(aOut), .portAOe(aOe), .portBIn(bIn), .portBOut(bOut), .portBOe(bOe), .handshakeAIn(h1),
		.handshakeAAuxIn(h2In), .handshakeAAuxOut(h2Out), .handshakeAAuxOe(h2Oe), .handshakeBIn(h3),
		.handshakeBAuxIn(h4In), .handshakeBAuxOut(h4Out), .handshakeBAuxOe(h4Oe));

	ppmc_periph periph (.clk(clk), .portAOut(aOut), .portAOe(aOe), .portBOut(bOut), .portBOe(bOe),
		.handshakeAAuxOut(h2Out), .handshakeAAuxOe(h2Oe), .handshakeBAuxOut(h4Out), .handshakeBAuxOe(h4Oe),
		.portAIn(aIn), .portBIn(bIn), .handshakeAIn(h1), .handshakeAAuxIn(h2In), .handshakeBIn(h3),
		.handshakeBAuxIn(h4In));

	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Held until waitrequest is sampled low; read high, write otherwise
	task automatic access(input logic rd, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		address <= a;
		writeData <= d;
		read <= rd;
		write <= ~rd;
		do begin
			@(posedge clk);
		end while (waitReq !== 1'b0);
		rv = readData;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		access(1'b0, a, d);
	endtask

	task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [7:0] exp, input string name);
		access(1'b1, a, 8'h00);
		chk(name, rv, exp);
	endtask

	// Present a word, strobe the first or third pin, then release
	task automatic latchIn(input logic [7:0] a, input logic [7:0] b, input logic third);
		periph.setPins(a, b, 1'b1);
		repeat (2) @(posedge clk);
		periph.setHs(~third, third);
		repeat (5) @(posedge clk);
		periph.setHs(1'b0, 1'b0);
		repeat (5) @(posedge clk);
		periph.setPins(8'h00, 8'h00, 1'b0);
	endtask

	initial begin
		repeat (20) @(posedge clk);
		chk("port A enables in reset", aOe, 8'h00);
		chk("port B enables in reset", bOe, 8'h00);
		resetn <= 1'b1;
		foreach (regList[i]) rdChk(regList[i], 8'h00, "reset value");
		foreach (regList[i]) begin
			wr(regList[i], 8'h8a);
			rdChk(regList[i], 8'h8a, "register readback");
		end
		rdChk(5'h1f, 8'h00, "unmapped read");
		foreach (regList[i]) wr(regList[i], 8'h00);
		wr(OFF_STAT, 8'h0f);
		$display("Test registers done");
		wr(OFF_GCR, 8'h30);
		latchIn(8'h3c, 8'h00, 1'b0);
		latchIn(8'hc3, 8'h00, 1'b0);
		rdChk(OFF_STAT, 8'hf1, "status after latch");
		wr(OFF_STAT, 8'h0f);
		rdChk(OFF_STAT, 8'hf0, "status cleared");
		rdChk(OFF_DATA_A, 8'h3c, "first latched A");
		rdChk(OFF_DATA_A, 8'hc3, "second latched A");
		latchIn(8'h00, 8'h96, 1'b1);
		rdChk(OFF_DATA_B, 8'h96, "latched B");
		$display("Test latched input done");
		wr(OFF_CTLA, 8'h80);
		wr(OFF_DDRA, 8'h0f);
		wr(OFF_DATA_A, 8'h5c);
		periph.setPins(8'ha0, 8'h00, 1'b1);
		repeat (4) @(posedge clk);
		chk("port A enables", aOe, 8'h0f);
		chk("port A outputs", aOut & 8'h0f, 8'h0c);
		rdChk(OFF_DATA_A, 8'hac, "live port A");
		periph.setPins(8'h00, 8'h00, 1'b0);
		wr(OFF_CTLA, 8'h70);
		wr(OFF_DDRA, 8'hff);
		wr(OFF_DATA_A, 8'h61);
		wr(OFF_DATA_A, 8'h62);
		wr(OFF_DATA_A, 8'h63);
		@(posedge clk);
		chk("buffered output first", aOut, 8'h61);
		chk("aux A output ready", h2Out, 1'b0);
		periph.setHs(1'b1, 1'b0);
		repeat (4) @(posedge clk);
		periph.setHs(1'b0, 1'b0);
		repeat (4) @(posedge clk);
		chk("buffered output second", aOut, 8'h62);
		periph.setHs(1'b1, 1'b0);
		repeat (4) @(posedge clk);
		periph.setHs(1'b0, 1'b0);
		repeat (4) @(posedge clk);
		chk("aux A output drained", h2Out, 1'b1);
		$display("Test direction done");
		wr(OFF_GCR, 8'h32);
		wr(OFF_CTLA, 8'h28);
		@(posedge clk);
		chk("aux A enable", h2Oe, 1'b1);
		chk("aux A asserted high sense", h2Out, 1'b1);
		wr(OFF_CTLA, 8'h20);
		@(posedge clk);
		chk("aux A negated high sense", h2Out, 1'b0);
		wr(OFF_GCR, 8'h30);
		wr(OFF_CTLA, 8'h28);
		@(posedge clk);
		chk("aux A asserted low sense", h2Out, 1'b0);
		$display("Test aux output done");
		wr(OFF_DDRB, 8'hff);
		wr(OFF_GCR, 8'hb0);
		wr(OFF_CTLA, 8'h00);
		@(posedge clk);
		chk("bidir B idle enables", bOe, 8'h00);
		wr(OFF_DATA_B, 8'h5a);
		repeat (2) @(posedge clk);
		chk("aux A drives", h2Oe, 1'b1);
		chk("aux A data ready", h2Out, 1'b0);
		periph.setHs(1'b1, 1'b0);
		repeat (4) @(posedge clk);
		chk("bidir B enables on ack", bOe, 8'hff);
		chk("bidir B word", bOut, 8'h5a);
		periph.setHs(1'b0, 1'b0);
		repeat (4) @(posedge clk);
		chk("bidir B enables released", bOe, 8'h00);
		chk("aux A buffer empty", h2Out, 1'b1);
		latchIn(8'h00, 8'h77, 1'b1);
		rdChk(OFF_DATA_B, 8'h77, "bidir B input");
		$display("Test bidirectional byte done");
		wr(OFF_GCR, 8'hf0);
		wr(OFF_DATA_A, 8'h12);
		wr(OFF_DATA_B, 8'h34);
		periph.setHs(1'b1, 1'b0);
		repeat (4) @(posedge clk);
		chk("bidir A enables on ack", aOe, 8'hff);
		chk("bidir high byte", aOut, 8'h12);
		chk("bidir low byte", bOut, 8'h34);
		periph.setHs(1'b0, 1'b0);
		repeat (4) @(posedge clk);
		latchIn(8'hab, 8'hcd, 1'b1);
		rdChk(OFF_DATA_A, 8'hab, "bidir input high");
		rdChk(OFF_DATA_B, 8'hcd, "bidir input low");
		$display("Test bidirectional word done");
		wr(OFF_DDRA, 8'h00);
		wr(OFF_DDRB, 8'h00);
		wr(OFF_GCR, 8'h70);
		wr(OFF_CTLB, 8'h00);
		latchIn(8'h11, 8'h22, 1'b1);
		rdChk(OFF_DATA_A, 8'h11, "word input high");
		rdChk(OFF_DATA_B, 8'h22, "word input low");
		wr(OFF_CTLA, 8'h30);
		@(posedge clk);
		chk("aux A idle in word mode", h2Out, 1'b1);
		wr(OFF_DDRA, 8'hff);
		wr(OFF_DDRB, 8'hff);
		wr(OFF_CTLB, 8'h70);
		wr(OFF_DATA_A, 8'h56);
		wr(OFF_DATA_B, 8'h78);
		@(posedge clk);
		chk("word output high", aOut, 8'h56);
		chk("word output low", bOut, 8'h78);
		chk("aux B word ready", h4Out, 1'b0);
		periph.setHs(1'b0, 1'b1);
		repeat (4) @(posedge clk);
		periph.setHs(1'b0, 1'b0);
		repeat (4) @(posedge clk);
		chk("aux B word taken", h4Out, 1'b1);
		$display("Test unidirectional word done");
		test_done();
	end

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		$display("Error watchdog expected finish seen timeout");
		test_done();
	end
endmodule

/* verification/ppmc_periph.sv */
// Peripheral model on the port and handshake pins
`timescale 1ns/1ns
module ppmc_periph (
	input wire logic clk,
	input wire logic [7:0] portAOut,
	input wire logic [7:0] portAOe,
	input wire logic [7:0] portBOut,
	input wire logic [7:0] portBOe,
	input wire logic handshakeAAuxOut,
	input wire logic handshakeAAuxOe,
	input wire logic handshakeBAuxOut,
	input wire logic handshakeBAuxOe,
	output logic [7:0] portAIn,
	output logic [7:0] portBIn,
	output logic handshakeAIn,
	output logic handshakeAAuxIn,
	output logic handshakeBIn,
	output logic handshakeBAuxIn
);
	logic [7:0] valA = 8'h00;
	logic [7:0] valB = 8'h00;
	logic drive = 1'b0;
	logic firstPin = 1'b1;
	logic thirdPin = 1'b1;

	// Released lines float to the pull-up level
	assign portAIn = (portAOe & portAOut) | (~portAOe & (drive ? valA : 8'hff));
	assign portBIn = (portBOe & portBOut) | (~portBOe & (drive ? valB : 8'hff));
	assign handshakeAAuxIn = handshakeAAuxOe ? handshakeAAuxOut : 1'b1;
	assign handshakeBAuxIn = handshakeBAuxOe ? handshakeBAuxOut : 1'b1;
	assign handshakeAIn = firstPin;
	assign handshakeBIn = thirdPin;

	task automatic setPins(input logic [7:0] a, input logic [7:0] b, input logic en);
		@(posedge clk);
		valA <= a;
		valB <= b;
		drive <= en;
	endtask

	// Asserted level is low, the bench keeps these sense bits clear
	task automatic setHs(input logic first, input logic third);
		@(posedge clk);
		firstPin <= ~first;
		thirdPin <= ~third;
	endtask
endmodule
